// >>> shared/ddrpd_pkg.sv
package ddrpd_pkg;
  // link clock period for ns rounding, ns; bench link clock is 80 ns
  localparam int LINK_CK_NS = 125;
  localparam int LINK_DIV = 4;
  // times in link clock cycles (nCK); _NS names in ns
  localparam int PD_EXIT_NCK = 4;
  localparam int PD_EXIT_NS = 6;
  localparam int CKE_PULSE_NCK = 3;
  localparam int CKE_PULSE_NS = 5;
  localparam int CMD_DISABLE_NCK = 4;
  localparam int ACT_PDE_NCK = 2;
  localparam int RD_PDE_EXTRA = 5;
  localparam int WR_BL8_EXTRA = 4;
  localparam int WR_BC4_EXTRA = 2;
  localparam int MOD_NCK = 24;
  localparam int PDA_MRS_NCK = 16;
  localparam int PDA_MRS_NS = 10;
  localparam int LVL_DQS_EN_NCK = 25;
  localparam int LVL_FIRST_STROBE_NCK = 40;
  localparam int PARITY_LATENCY = 4;
  localparam int PAR_ALERT_ON_NS = 6;
  localparam int PAR_ALERT_PW_MIN = 56;
  localparam int PAR_ALERT_PW_MAX = 128;
  localparam int PAR_ALERT_RSP_NCK = 57;
  localparam int CRC_ALERT_MIN_NS = 3;
  localparam int CRC_ALERT_MAX_NS = 13;
  localparam int CHECKSUM_ALERT_PULSE_WIDTH_MIN = 6;
  localparam int CHECKSUM_ALERT_PULSE_WIDTH_MAX = 10;
  localparam int RL = 15;
  localparam int WL = 11;
  localparam int WR_NCK = 16;
  // system clock period, ns
  localparam int SYS_NS = 10;
  // ns minimum at link period rounded up, then max with nCK term
  localparam int PD_EXIT_CYC =
    ((PD_EXIT_NS + LINK_CK_NS - 1) / LINK_CK_NS > PD_EXIT_NCK) ?
    (PD_EXIT_NS + LINK_CK_NS - 1) / LINK_CK_NS : PD_EXIT_NCK;
  localparam int CKE_PULSE_CYC =
    ((CKE_PULSE_NS + LINK_CK_NS - 1) / LINK_CK_NS > CKE_PULSE_NCK) ?
    (CKE_PULSE_NS + LINK_CK_NS - 1) / LINK_CK_NS : CKE_PULSE_NCK;
  localparam int PDA_MRS_CYC =
    ((PDA_MRS_NS + LINK_CK_NS - 1) / LINK_CK_NS > PDA_MRS_NCK) ?
    (PDA_MRS_NS + LINK_CK_NS - 1) / LINK_CK_NS : PDA_MRS_NCK;
  // alert delays in system cycles: longest rounds down, min one
  localparam int PAR_ALERT_ON_SYS = (PAR_ALERT_ON_NS / SYS_NS) < 1 ? 1 :
                                    PAR_ALERT_ON_NS / SYS_NS;
  localparam int CRC_ALERT_SYS = (CRC_ALERT_MAX_NS / SYS_NS) < 1 ? 1 :
                                 CRC_ALERT_MAX_NS / SYS_NS;
  localparam int PAR_ALERT_PW = 64;
  localparam int CHECKSUM_ALERT_PULSE_WIDTH = 8;

  typedef enum logic [2:0] {
    DDRPD_CMD_DES, DDRPD_CMD_ACT, DDRPD_CMD_PRE, DDRPD_CMD_REF,
    DDRPD_CMD_RD, DDRPD_CMD_WR, DDRPD_CMD_WRA, DDRPD_CMD_MRS
  } ddrpd_cmd_t;
endpackage

// >>> shared/ddrpd_if.sv
`timescale 1ns/1ps
interface ddrpd_if;
  logic       ck;
  logic       cke;
  logic [2:0] cmd;
  logic       par_err;
  logic       crc_err;
  logic       alert_n;
  modport ctrl (output ck, output cke, output cmd, output par_err, output crc_err,
                input alert_n);
  modport dram (input ck, input cke, input cmd, input par_err, input crc_err,
                output alert_n);
endinterface

// >>> logic/ddrpd_dram.sv
`timescale 1ns/1ps
// Contract
// - wait exit delay before commands after power-down
// - hold each clock-enable level minimum pulse
// - command path disabled four cycles after entry
// - power-down residency within minimum and maximum; only the minimum is enforced
// - entry two cycles after activate/precharge/refresh
// - entry read latency plus five after read
// - entry after write plus recovery, burst extra
// - entry after auto-precharge write plus one
// - entry waits mode update delay after MRS
// - per-device MRS spaced sixteen cycles apart
// - per-device mode update before other commands
// - leveling strobe waits 25, first edge 40; no leveling logic is implemented
// - parity checked four cycles; window commands dropped
// - parity alert within latency plus six ns
// - parity alert held 56 to 128 cycles
// - controller issues deselect within 57 cycles; the controller does so only when PAR_PERSIST is set
// - checksum alert within 3 to 13 ns
// - checksum alert held 6 to 10 cycles
module ddrpd_dram (
  input  wire logic CLK,          // system clock
  input  wire logic RST,          // async reset
  ddrpd_if.dram     LINK,         // link to controller
  output logic      CMD_VALID,    // pulse: command executed
  output logic [2:0] CMD_CODE,    // executed command
  output logic      POWERED_DOWN, // command path disabled
  output logic      PAR_ALERT,    // parity alert level
  output logic      CRC_ALERT     // checksum alert level
);
  import ddrpd_pkg::*;

  typedef struct packed {
    logic [1:0] ck_s;
    logic [1:0] cke_s;
    logic [5:0] cmd_s0;
    logic [5:0] cmd_s1;
    logic       ck_d;
    logic       cke_d;
    logic [2:0] pd_cnt;
    logic       pd;
    logic [2:0] drop_cnt;
    logic [2:0] par_dly;
    logic [7:0] par_pw;
    logic [3:0] crc_dly;
    logic [3:0] crc_pw;
    logic       valid;
    logic [2:0] code;
    logic       alert_n;
  } ddrpd_dram_st_t;

  ddrpd_dram_st_t st_reg, st_next;

  logic ck_rise;
  assign ck_rise = st_reg.ck_s[1] & ~st_reg.ck_d;

  always_comb begin
    st_next = st_reg;
    st_next.ck_s = {st_reg.ck_s[0], LINK.ck};
    st_next.cke_s = {st_reg.cke_s[0], LINK.cke};
    st_next.cmd_s0 = {1'b0, LINK.crc_err, LINK.par_err, LINK.cmd};
    st_next.cmd_s1 = st_reg.cmd_s0;
    st_next.ck_d = st_reg.ck_s[1];
    st_next.valid = 1'b0;
    if (st_reg.par_dly != 3'h0) begin
      st_next.par_dly = st_reg.par_dly - 3'h1;
      if (st_reg.par_dly == 3'h1) begin
        st_next.par_pw = 8'(PAR_ALERT_PW);
      end
    end else if (ck_rise && st_reg.par_pw != 8'h00) begin
      st_next.par_pw = st_reg.par_pw - 8'h01;
    end
    if (st_reg.crc_dly != 4'h0) begin
      st_next.crc_dly = st_reg.crc_dly - 4'h1;
      if (st_reg.crc_dly == 4'h1) begin
        st_next.crc_pw = 4'(CHECKSUM_ALERT_PULSE_WIDTH);
      end
    end else if (ck_rise && st_reg.crc_pw != 4'h0) begin
      st_next.crc_pw = st_reg.crc_pw - 4'h1;
    end
    if (ck_rise) begin
      st_next.cke_d = st_reg.cke_s[1];
      if (!st_reg.cke_s[1]) begin
        if (st_reg.cke_d) begin
          st_next.pd_cnt = 3'(CMD_DISABLE_NCK);
        end else if (st_reg.pd_cnt > 3'h1) begin
          st_next.pd_cnt = st_reg.pd_cnt - 3'h1;
        end else begin
          st_next.pd = 1'b1;
        end
      end else begin
        st_next.pd = 1'b0;
        st_next.pd_cnt = 3'h0;
      end
      if (st_reg.drop_cnt != 3'h0) begin
        st_next.drop_cnt = st_reg.drop_cnt - 3'h1;
      end
      if (st_reg.cmd_s1[3] && st_reg.par_pw == 8'h00 && st_reg.par_dly == 3'h0) begin
        st_next.drop_cnt = 3'(PARITY_LATENCY);
        st_next.par_dly = 3'(PAR_ALERT_ON_SYS);
      end else if (!st_reg.pd && st_reg.drop_cnt == 3'h0 &&
                   st_reg.cmd_s1[2:0] != 3'h0) begin
        st_next.valid = 1'b1;
        st_next.code = st_reg.cmd_s1[2:0];
      end
      if (st_reg.cmd_s1[4] && st_reg.crc_pw == 4'h0 && st_reg.crc_dly == 4'h0) begin
        st_next.crc_dly = 4'(CRC_ALERT_SYS);
      end
    end
    st_next.alert_n = ~((st_next.par_pw != 8'h00) | (st_next.crc_pw != 4'h0));
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_reg <= '0;
      st_reg.alert_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign LINK.alert_n = st_reg.alert_n;
  assign CMD_VALID = st_reg.valid;
  assign CMD_CODE = st_reg.code;
  assign POWERED_DOWN = st_reg.pd;
  assign PAR_ALERT = st_reg.par_pw != 8'h00;
  assign CRC_ALERT = st_reg.crc_pw != 4'h0;
endmodule // ddrpd_dram

// >>> logic/ddrpd_ctrl.sv
`timescale 1ns/1ps
module ddrpd_ctrl (
  input  wire logic       CLK,       // system clock
  input  wire logic       RST,       // async reset
  ddrpd_if.ctrl           LINK,      // link to device
  input  wire logic [2:0] REQ_CMD,   // requested command
  input  wire logic       REQ_VALID, // request present
  output logic            REQ_READY, // pulse: request issued
  input  wire logic       REQ_PD,    // level: want power-down
  input  wire logic       PDA_MODE,  // per-device addressing on
  input  wire logic       BC4_FIXED, // burst-chop-four fixed
  input  wire logic       PAR_PERSIST, // persistent parity mode
  input  wire logic       INJ_PAR,   // corrupt next parity
  input  wire logic       INJ_CRC,   // corrupt next write data
  output logic            IN_PD,     // device in power-down
  output logic            ALERT_SEEN // alert observed
);
  import ddrpd_pkg::*;

  typedef struct packed {
    logic [1:0] div;
    logic       ck;
    logic       cke;
    logic [2:0] cmd;
    logic       par;
    logic       crc;
    logic [7:0] cke_hold;
    logic [7:0] pde_wait;
    logic [7:0] cmd_wait;
    logic [7:0] mrs_wait;
    logic [7:0] mod_wait;
    logic [7:0] pd_time;
    logic       ready;
    logic [1:0] al_s;
    logic       alert;
  } ddrpd_ctrl_st_t;

  ddrpd_ctrl_st_t st_reg, st_next;

  function automatic logic [7:0] mx(input logic [7:0] a, input int b);
    mx = (a > 8'(b)) ? a : 8'(b);
  endfunction

  logic edge_now;
  assign edge_now = (st_reg.div == 2'(LINK_DIV - 1)) & ~st_reg.ck;

  always_comb begin
    st_next = st_reg;
    st_next.ready = 1'b0;
    st_next.al_s = {st_reg.al_s[0], ~LINK.alert_n};
    st_next.alert = st_reg.al_s[1];
    st_next.div = st_reg.div + 2'h1;
    if (st_reg.div == 2'(LINK_DIV - 1)) begin
      st_next.div = 2'h0;
      st_next.ck = ~st_reg.ck;
    end
    if (edge_now) begin
      st_next.cmd = 3'h0;
      st_next.par = 1'b0;
      st_next.crc = 1'b0;
      if (st_reg.cke_hold != 8'h0) st_next.cke_hold = st_reg.cke_hold - 8'h1;
      if (st_reg.pde_wait != 8'h0) st_next.pde_wait = st_reg.pde_wait - 8'h1;
      if (st_reg.cmd_wait != 8'h0) st_next.cmd_wait = st_reg.cmd_wait - 8'h1;
      if (st_reg.mrs_wait != 8'h0) st_next.mrs_wait = st_reg.mrs_wait - 8'h1;
      if (st_reg.mod_wait != 8'h0) st_next.mod_wait = st_reg.mod_wait - 8'h1;
      if (!st_reg.cke) st_next.pd_time = st_reg.pd_time + 8'h1;
      if (st_reg.cke && REQ_PD && st_reg.cke_hold == 8'h0 && st_reg.pde_wait == 8'h0) begin
        st_next.cke = 1'b0;
        st_next.cke_hold = 8'(CKE_PULSE_CYC);
        st_next.pd_time = 8'h0;
        st_next.cmd_wait = 8'(CMD_DISABLE_NCK);
      end else if (!st_reg.cke) begin
        if (!REQ_PD && st_reg.cke_hold == 8'h0) begin
          st_next.cke = 1'b1;
          st_next.cke_hold = 8'(CKE_PULSE_CYC);
          st_next.cmd_wait = 8'(PD_EXIT_CYC);
        end
      end else if (st_reg.alert && PAR_PERSIST) begin
        st_next.cmd = 3'h0;
      end else if (REQ_VALID && !REQ_PD && st_reg.cmd_wait == 8'h0 &&
                   !(REQ_CMD == 3'(DDRPD_CMD_MRS) && st_reg.mrs_wait != 8'h0) &&
                   !(REQ_CMD != 3'(DDRPD_CMD_MRS) && st_reg.mod_wait != 8'h0)) begin
        st_next.cmd = REQ_CMD;
        st_next.par = INJ_PAR;
        st_next.ready = 1'b1;
        unique case (ddrpd_cmd_t'(REQ_CMD))
          DDRPD_CMD_ACT, DDRPD_CMD_PRE, DDRPD_CMD_REF:
            st_next.pde_wait = mx(st_reg.pde_wait, ACT_PDE_NCK);
          DDRPD_CMD_RD:
            st_next.pde_wait = mx(st_reg.pde_wait, RL + RD_PDE_EXTRA);
          DDRPD_CMD_WR: begin
            st_next.crc = INJ_CRC;
            st_next.pde_wait = mx(st_reg.pde_wait, WL + WR_NCK +
              (BC4_FIXED ? WR_BC4_EXTRA : WR_BL8_EXTRA));
          end
          DDRPD_CMD_WRA: begin
            st_next.crc = INJ_CRC;
            st_next.pde_wait = mx(st_reg.pde_wait, WL + WR_NCK + 1 +
              (BC4_FIXED ? WR_BC4_EXTRA : WR_BL8_EXTRA));
          end
          DDRPD_CMD_MRS: begin
            st_next.pde_wait = mx(st_reg.pde_wait, MOD_NCK);
            if (PDA_MODE) begin
              st_next.mrs_wait = 8'(PDA_MRS_CYC);
              st_next.mod_wait = 8'(MOD_NCK);
            end
          end
          DDRPD_CMD_DES: st_next.ready = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_reg <= '0;
      st_reg.cke <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign LINK.ck = st_reg.ck;
  assign LINK.cke = st_reg.cke;
  assign LINK.cmd = st_reg.cmd;
  assign LINK.par_err = st_reg.par;
  assign LINK.crc_err = st_reg.crc;
  assign REQ_READY = st_reg.ready;
  assign IN_PD = ~st_reg.cke;
  assign ALERT_SEEN = st_reg.alert;
endmodule // ddrpd_ctrl

// >>> test/ddrpd_chk.sv
`timescale 1ns/1ps
module ddrpd_chk
  import ddrpd_pkg::*;
(
  input wire logic       CLK,     // sys clock
  input wire logic       RST,     // reset
  input wire logic       ck,      // link clock
  input wire logic       cke,     // clock enable
  input wire logic [2:0] cmd,     // command
  input wire logic       par_err, // bad parity
  input wire logic       crc_err, // bad checksum
  input wire logic       alert_n  // alert
);
  localparam int PW = 48;
  localparam int CW = 12;
  logic       ck_d, cke_d, edge_ck;
  logic [7:0] cke_age, cmd_age, alert_len;
  logic [2:0] last_cmd;
  int         need;
  assign edge_ck = ck && !ck_d;
  always_comb begin
    case (last_cmd)
      DDRPD_CMD_RD:  need = RL + RD_PDE_EXTRA;
      DDRPD_CMD_WR:  need = WL + WR_BC4_EXTRA + WR_NCK;
      DDRPD_CMD_WRA: need = WL + WR_BC4_EXTRA + WR_NCK + 1;
      DDRPD_CMD_MRS: need = MOD_NCK;
      default:       need = ACT_PDE_NCK;
    endcase
  end
  // link rises since last level change or command
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ck_d      <= 1'b0;
      cke_d     <= 1'b1;
      cke_age   <= 8'hff;
      cmd_age   <= 8'hff;
      last_cmd  <= 3'h0;
      alert_len <= 8'h00;
    end else begin
      ck_d      <= ck;
      cke_d     <= cke;
      alert_len <= alert_n ? 8'h00 : alert_len + {7'h00, edge_ck};
      if (cke != cke_d) cke_age <= 8'h00;
      else if (edge_ck && cke_age != 8'hff) cke_age <= cke_age + 8'h01;
      if (edge_ck && cmd != 3'h0) last_cmd <= cmd;
      if (edge_ck && cmd != 3'h0) cmd_age <= 8'h00;
      else if (edge_ck && cmd_age != 8'hff) cmd_age <= cmd_age + 8'h01;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  cke_hold_a: assert property (cke != cke_d |-> cke_age >= CKE_PULSE_CYC - 1)
    else $error("enable level too short");
  exit_wait_a: assert property (edge_ck && cke && cmd != 3'h0 |-> cke_age >= PD_EXIT_CYC - 1)
    else $error("command too soon after exit");
  pd_quiet_a: assert property (!cke |-> cmd == 3'h0)
    else $error("command during power-down");
  pd_gap_a: assert property (cke_d && !cke |-> cmd_age >= need - 1)
    else $error("power-down entry too soon");
  par_alert_a: assert property (edge_ck && par_err |-> ##[1:PW] !alert_n)
    else $error("parity alert late");
  crc_alert_a: assert property (edge_ck && crc_err |-> ##[1:CW] !alert_n)
    else $error("checksum alert late");
  alert_width_a: assert property ($rose(alert_n) |->
    (alert_len >= CHECKSUM_ALERT_PULSE_WIDTH_MIN && alert_len <= CHECKSUM_ALERT_PULSE_WIDTH_MAX) ||
    (alert_len >= PAR_ALERT_PW_MIN && alert_len <= PAR_ALERT_PW_MAX)) else $error("alert width");
  alert_cap_a: assert property (alert_len <= PAR_ALERT_PW_MAX)
    else $error("alert too long");
  cover property (edge_ck && par_err);
  cover property (edge_ck && crc_err);
  cover property (cke_d && !cke);
endmodule // ddrpd_chk

// >>> test/ddrpd_tb_top.sv
`timescale 1ns/1ps
module sdram_powerdown_parity_alert_timing_tb_top;
  import ddrpd_pkg::*;
  logic       CLK = 1'b0;
  logic       RST = 1'b1;
  logic [2:0] rc = 3'h0;
  logic       rv = 1'b0, pd = 1'b0, pda = 1'b0, bc4 = 1'b0, ip = 1'b0, ic = 1'b0, pp = 1'b0;
  logic       rdy, inpd, seen, cv, pdn, pa, ca, ok;
  logic [2:0] code;
  int         fails = 0, checked = 0, cyc = 0, at = 0, plen = 0, clen = 0, pn = 0, cn = 0;
  ddrpd_if lnk ();
  ddrpd_ctrl i_ddrpd_ctrl (.CLK(CLK), .RST(RST), .LINK(lnk.ctrl), .REQ_CMD(rc),
    .REQ_VALID(rv), .REQ_READY(rdy), .REQ_PD(pd), .PDA_MODE(pda), .BC4_FIXED(bc4),
    .PAR_PERSIST(pp), .INJ_PAR(ip), .INJ_CRC(ic), .IN_PD(inpd), .ALERT_SEEN(seen));
  ddrpd_dram i_ddrpd_dram (.CLK(CLK), .RST(RST), .LINK(lnk.dram), .CMD_VALID(cv),
    .CMD_CODE(code), .POWERED_DOWN(pdn), .PAR_ALERT(pa), .CRC_ALERT(ca));
  ddrpd_chk i_ddrpd_chk (.CLK(CLK), .RST(RST), .ck(lnk.ck), .cke(lnk.cke), .cmd(lnk.cmd),
    .par_err(lnk.par_err), .crc_err(lnk.crc_err), .alert_n(lnk.alert_n));
  always #5 CLK = ~CLK;
  // alert lengths in system cycles
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    pn <= (pa === 1'b1) ? pn + 1 : 0;
    cn <= (ca === 1'b1) ? cn + 1 : 0;
    if (pa !== 1'b1 && pn > 0) plen <= pn;
    if (ca !== 1'b1 && cn > 0) clen <= cn;
  end
  task automatic chk(string what, int lo, int hi, logic [15:0] got);
    checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fails++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic send(logic [2:0] c, logic p, logic e);
    int n;
    rc <= c;
    ip <= p;
    ic <= e;
    rv <= 1'b1;
    for (n = 0; n < 400 && rdy !== 1'b1; n++) @(posedge CLK);
    chk("ready", 1, 1, rdy);
    at = cyc;
    rv <= 1'b0;
    ip <= 1'b0;
    ic <= 1'b0;
    ok = 1'b0;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge CLK);
      if (cv === 1'b1) ok = 1'b1;
    end
    if (ok) chk("code", c, c, code);
  endtask
  task automatic t_alerts;
    for (int c = 1; c < 8; c++) begin
      send(3'(c), 1'b0, 1'b0);
      chk("executed", 1, 1, ok);
    end
    send(DDRPD_CMD_ACT, 1'b1, 1'b0);
    send(DDRPD_CMD_PRE, 1'b0, 1'b0);
    chk("dropped", 0, 0, ok);
    repeat (600) @(posedge CLK);
    chk("parity width", PAR_ALERT_PW_MIN * 8, PAR_ALERT_PW_MAX * 8, plen);
    send(DDRPD_CMD_WR, 1'b0, 1'b1);
    repeat (100) @(posedge CLK);
    chk("checksum width", CHECKSUM_ALERT_PULSE_WIDTH_MIN * 8, CHECKSUM_ALERT_PULSE_WIDTH_MAX * 8, clen);
  endtask
  // persistent parity: no command but deselect while alert stands
  task automatic t_persist;
    int n;
    pp <= 1'b1;
    send(DDRPD_CMD_ACT, 1'b1, 1'b0);
    rc <= DDRPD_CMD_PRE;
    rv <= 1'b1;
    for (n = 0; n < 200 && rdy !== 1'b1; n++) @(posedge CLK);
    chk("held off", 0, 0, rdy);
    rv <= 1'b0;
    pp <= 1'b0;
    repeat (600) @(posedge CLK);
  endtask
  task automatic t_pda;
    int t;
    pda <= 1'b1;
    send(DDRPD_CMD_MRS, 1'b0, 1'b0);
    t = at;
    send(DDRPD_CMD_MRS, 1'b0, 1'b0);
    chk("mrs spacing", PDA_MRS_CYC * 8 - 4, (PDA_MRS_CYC + 2) * 8, at - t);
    t = at;
    send(DDRPD_CMD_ACT, 1'b0, 1'b0);
    chk("mrs to other", MOD_NCK * 8 - 4, 999, at - t);
    pda <= 1'b0;
  endtask
  task automatic t_pd(logic [2:0] c, logic b, int gap);
    int n, t;
    bc4 <= b;
    send(c, 1'b0, 1'b0);
    pd <= 1'b1;
    while (lnk.cke !== 1'b0 && cyc - at < 999) @(posedge CLK);
    chk("entry gap", gap * 8 - 4, 999, cyc - at);
    t = cyc;
    for (n = 0; n < 80 && pdn !== 1'b1; n++) @(posedge CLK);
    chk("disable delay", CMD_DISABLE_NCK * 8 - 4, CMD_DISABLE_NCK * 8 + 8, n);
    pd <= 1'b0;
    while (lnk.cke !== 1'b1 && cyc - t < 400) @(posedge CLK);
    chk("residency", CKE_PULSE_CYC * 8 - 4, 399, cyc - t);
    t = cyc;
    send(DDRPD_CMD_ACT, 1'b0, 1'b0);
    chk("exit wait", PD_EXIT_CYC * 8 - 4, 999, at - t);
    chk("after exit", 1, 1, ok);
  endtask
  task automatic test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    t_alerts;
    t_persist;
    t_pda;
    t_pd(DDRPD_CMD_ACT, 1'b0, ACT_PDE_NCK);
    t_pd(DDRPD_CMD_RD, 1'b0, RL + RD_PDE_EXTRA);
    t_pd(DDRPD_CMD_WR, 1'b1, WL + WR_BC4_EXTRA + WR_NCK);
    t_pd(DDRPD_CMD_WRA, 1'b0, WL + WR_BL8_EXTRA + WR_NCK + 1);
    t_pd(DDRPD_CMD_MRS, 1'b0, MOD_NCK);
    test_done;
  end
  initial begin
    #200000;
    fails++;
    test_done;
  end
endmodule // sdram_powerdown_parity_alert_timing_tb_top
